/* shared/vic_pkg.sv */
// constants for the vectored interrupt controller
package vic_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RELOAD = 8'h08;
  localparam logic [7:0] OFS_FLAGS_UP = 8'h0C;
  localparam logic [7:0] OFS_ENABLE_UP = 8'h10;
  localparam logic [7:0] OFS_PRIO_EIGHT = 8'h14;
  localparam logic [7:0] OFS_PRIO_NINE = 8'h18;
  localparam logic [7:0] OFS_PRIO_TEN = 8'h1C;
  localparam logic [7:0] OFS_TIMER = 8'h20;
  // ****************************************
  // control and status fields
  // ****************************************
  localparam int CTL_SHADOW_BIT = 16;
  localparam int CTL_MULTI_VECTOR_SELECT_BIT = 12;
  localparam int CTL_TPC_LSB = 8;
  localparam int STAT_RIPL_LSB = 8;
  localparam logic [31:0] CTL_MASK = 32'h0001_171F;
  localparam logic [31:0] STAT_MASK = 32'h0000_073F;
  localparam logic [31:0] PRIO_MASK = 32'h1F1F_1F1F;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  localparam logic [31:0] FLAG_MASK = 32'hFFFF_FF80;
  // ****************************************
  // sources and vectors
  // ****************************************
  localparam int IRQ_BASE = 32;
  localparam int NUM_VEC = 12;
  localparam logic [5:0] VEC_BASE = 6'h20;
  localparam int NUM_EXT = 5;
endpackage : vic_pkg

/* core/vic_top.sv */
// vectored interrupt controller for requests 39 to 63
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module vic_top #(
  parameter int NUM_SRC = 25
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // peripheral requests 39..63, pulses
  input wire logic [NUM_SRC-1:0] src_req,
  // external interrupt pins
  input wire logic [vic_pkg::NUM_EXT-1:0] ext_pin,
  // core side
  output logic core_irq,
  output logic [5:0] core_vector,
  output logic [2:0] core_level,
  output logic core_shadow,
  output logic core_multi,
  output logic [vic_pkg::NUM_EXT-1:0] ext_event,
  output logic proximity_running
);
  // ****************************************
  // registers
  // ****************************************
  logic [31:0] interrupt_control;
  logic [31:0] proximity_reload_value;
  logic [31:0] proximity_timer;
  logic [31:0] pending_flags_upper;
  logic [31:0] enable_bits_upper;
  logic [31:0] priority_fields_eight;
  logic [31:0] priority_fields_nine;
  logic [31:0] priority_fields_ten;
  logic [2:0] requested_priority_level;
  logic [5:0] presented_handler_index;
  logic [vic_pkg::NUM_EXT-1:0] ext_s1;
  logic [vic_pkg::NUM_EXT-1:0] ext_s2;
  logic [vic_pkg::NUM_EXT-1:0] ext_s3;

  // vector (offset from 32) of request 39+i
  function automatic logic [3:0] vec_of(input int i);
    int r;
    r = i + 39;
    if (r <= 41) return 4'h0;
    else if (r <= 44) return 4'h1;
    else if (r <= 47) return 4'h2;
    else if (r <= 49) return 4'h3;
    else if (r <= 52) return 4'h4;
    else if (r <= 55) return 4'h5;
    else if (r <= 58) return 4'h6;
    else if (r == 59) return 4'h7;
    else return 4'(r - 52);
  endfunction

  // priority/subpriority field of vector offset v
  function automatic logic [4:0] prio_of(input logic [3:0] v, input logic [31:0] p8,
                                         input logic [31:0] p9, input logic [31:0] p10);
    logic [31:0] w;
    w = (v < 4'h4) ? p8 : ((v < 4'h8) ? p9 : p10);
    return w[{v[1:0], 3'b000} +: 5];
  endfunction

  // software write strobe aimed at offset a
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] addr, input logic wr);
    return wr && (addr == a);
  endfunction

  // ****************************************
  // external edge detection
  // ****************************************
  // two-flop synchroniser; only ext_s2 reads ext_s1
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_s1 <= '0;
      ext_s2 <= '0;
    end else begin
      ext_s1 <= ext_pin;
      ext_s2 <= ext_s1;
    end
  end

  // edge select per pin, one-cycle event
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_s3 <= '0;
      ext_event <= '0;
    end else begin
      ext_s3 <= ext_s2;
      for (int k = 0; k < vic_pkg::NUM_EXT; k++) begin
        ext_event[k] <= interrupt_control[k] ? (ext_s2[k] & ~ext_s3[k])
                                             : (~ext_s2[k] & ext_s3[k]);
      end
    end
  end

  // ****************************************
  // arbitration
  // ****************************************
  logic [NUM_SRC-1:0] active;
  logic found;
  logic [3:0] win_vec;
  logic [4:0] win_prio;
  always_comb begin
    logic [4:0] p;
    logic [3:0] v;
    p = '0;
    v = '0;
    found = 1'b0;
    win_vec = '0;
    win_prio = '0;
    active = pending_flags_upper[31 -: NUM_SRC] & enable_bits_upper[31 -: NUM_SRC];
    for (int i = 0; i < NUM_SRC; i++) begin
      v = vec_of(i);
      p = prio_of(v, priority_fields_eight, priority_fields_nine, priority_fields_ten);
      // strict greater keeps earlier (lower) vector on ties
      if (active[i] && p[4:2] != 3'b000 && (!found || p > win_prio)) begin
        found = 1'b1;
        win_vec = v;
        win_prio = p;
      end
    end
  end

  // ****************************************
  // presentation and status
  // ****************************************
  // core_irq and core_level follow the winner one cycle later, core_vector too in multi-vector mode (zero in single mode)
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_irq <= 1'b0;
      core_vector <= '0;
      core_level <= '0;
      core_shadow <= 1'b0;
      core_multi <= 1'b0;
    end else begin
      core_irq <= found;
      core_multi <= interrupt_control[vic_pkg::CTL_MULTI_VECTOR_SELECT_BIT];
      core_shadow <= interrupt_control[vic_pkg::CTL_MULTI_VECTOR_SELECT_BIT] |
                     interrupt_control[vic_pkg::CTL_SHADOW_BIT];
      if (found) begin
        core_vector <= interrupt_control[vic_pkg::CTL_MULTI_VECTOR_SELECT_BIT] ?
                       (vic_pkg::VEC_BASE + 6'(win_vec)) : 6'h00;
        core_level <= win_prio[4:2];
      end
    end
  end

  // status: latest presented level and vector, writable while idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      requested_priority_level <= '0;
      presented_handler_index <= '0;
    end else if (found) begin
      requested_priority_level <= win_prio[4:2];
      presented_handler_index <= vic_pkg::VEC_BASE + 6'(win_vec);
    end else if (wr_hit(vic_pkg::OFS_STATUS, reg_addr, reg_wr)) begin
      requested_priority_level <= reg_wdata[vic_pkg::STAT_RIPL_LSB +: 3];
      presented_handler_index <= reg_wdata[5:0];
    end
  end

  // ****************************************
  // proximity timer
  // ****************************************
  logic [2:0] tpc;
  logic prox_start;
  assign tpc = interrupt_control[vic_pkg::CTL_TPC_LSB +: 3];
  // only a newly presented interrupt at or below the trigger level starts it
  assign prox_start = (tpc != 3'b000) && found && !core_irq &&
                      (win_prio[4:2] <= tpc);

  // count down from the reload value to zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      proximity_timer <= '0;
    end else if (prox_start) begin
      proximity_timer <= proximity_reload_value;
    end else if (proximity_timer != 32'h0000_0000) begin
      proximity_timer <= proximity_timer - 32'h0000_0001;
    end
  end

  // running while the count is above zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      proximity_running <= 1'b0;
    end else if (prox_start) begin
      proximity_running <= (proximity_reload_value != 32'h0000_0000);
    end else if (proximity_timer != 32'h0000_0000) begin
      proximity_running <= (proximity_timer != 32'h0000_0001);
    end else begin
      proximity_running <= 1'b0;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  // control: implemented bits only, spare bits stay zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      interrupt_control <= vic_pkg::RESET_ZERO;
    end else if (wr_hit(vic_pkg::OFS_CONTROL, reg_addr, reg_wr)) begin
      interrupt_control <= reg_wdata & vic_pkg::CTL_MASK;
    end
  end

  // timer reload value
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      proximity_reload_value <= vic_pkg::RESET_ZERO;
    end else if (wr_hit(vic_pkg::OFS_RELOAD, reg_addr, reg_wr)) begin
      proximity_reload_value <= reg_wdata;
    end
  end

  // upper enable bits, requests 39 and up
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_bits_upper <= vic_pkg::RESET_ZERO;
    end else if (wr_hit(vic_pkg::OFS_ENABLE_UP, reg_addr, reg_wr)) begin
      enable_bits_upper <= reg_wdata & vic_pkg::FLAG_MASK;
    end
  end

  // priority bytes of vectors 32 to 35
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      priority_fields_eight <= vic_pkg::RESET_ZERO;
    end else if (wr_hit(vic_pkg::OFS_PRIO_EIGHT, reg_addr, reg_wr)) begin
      priority_fields_eight <= reg_wdata & vic_pkg::PRIO_MASK;
    end
  end

  // priority bytes of vectors 36 to 39
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      priority_fields_nine <= vic_pkg::RESET_ZERO;
    end else if (wr_hit(vic_pkg::OFS_PRIO_NINE, reg_addr, reg_wr)) begin
      priority_fields_nine <= reg_wdata & vic_pkg::PRIO_MASK;
    end
  end

  // priority bytes of vectors 40 to 43
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      priority_fields_ten <= vic_pkg::RESET_ZERO;
    end else if (wr_hit(vic_pkg::OFS_PRIO_TEN, reg_addr, reg_wr)) begin
      priority_fields_ten <= reg_wdata & vic_pkg::PRIO_MASK;
    end
  end

  // pending flags: hardware set wins over software write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending_flags_upper <= vic_pkg::RESET_ZERO;
    end else if (wr_hit(vic_pkg::OFS_FLAGS_UP, reg_addr, reg_wr)) begin
      pending_flags_upper <= (reg_wdata & vic_pkg::FLAG_MASK) |
                             {src_req, 7'b0000000};
    end else begin
      pending_flags_upper <= pending_flags_upper | {src_req, 7'b0000000};
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  logic [31:0] rd_word;
  // read word chosen by address, spare offsets read zero
  always_comb begin
    case (reg_addr)
      vic_pkg::OFS_CONTROL: begin
        rd_word = interrupt_control;
      end
      vic_pkg::OFS_STATUS: begin
        rd_word = {21'h0_0000, requested_priority_level,
                   2'b00, presented_handler_index};
      end
      vic_pkg::OFS_RELOAD: begin
        rd_word = proximity_reload_value;
      end
      vic_pkg::OFS_FLAGS_UP: begin
        rd_word = pending_flags_upper;
      end
      vic_pkg::OFS_ENABLE_UP: begin
        rd_word = enable_bits_upper;
      end
      vic_pkg::OFS_PRIO_EIGHT: begin
        rd_word = priority_fields_eight;
      end
      vic_pkg::OFS_PRIO_NINE: begin
        rd_word = priority_fields_nine;
      end
      vic_pkg::OFS_PRIO_TEN: begin
        rd_word = priority_fields_ten;
      end
      vic_pkg::OFS_TIMER: begin
        rd_word = proximity_timer;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // read data stands the cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_word;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule // vic_top
`default_nettype wire

/* verification/vic_props.sv */
// assertion checker for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // core side
  input wire logic [4:0] ext_event,
  input wire logic core_irq,
  input wire logic [5:0] core_vector,
  input wire logic [2:0] core_level,
  input wire logic core_shadow,
  input wire logic core_multi
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_ctl_wr;
    reg_wr && reg_addr == vic_pkg::OFS_CONTROL;
  endsequence
  sequence s_rd_at(logic [7:0] a);
    $past(reg_rd) && $past(reg_addr) == a;
  endsequence
  property p_mode;
    logic b;
    (s_ctl_wr, b = reg_wdata[vic_pkg::CTL_MULTI_VECTOR_SELECT_BIT]) |-> ##2 core_multi == b;
  endproperty
  a_mode_write: assert property (p_mode)
    else $error("mode did not follow control write");
  a_shadow_multi: assert property (core_multi |-> core_shadow)
    else $error("no shadow in multi mode");
  a_single_no_vec: assert property (core_irq && !core_multi |-> core_vector == 6'h00)
    else $error("vector shown in single mode");
  a_multi_vec_range: assert property (core_irq && core_multi |-> core_vector inside {[6'h20:6'h2B]})
    else $error("vector out of range");
  a_level_nonzero: assert property (core_irq |-> core_level != 3'h0)
    else $error("priority zero presented");
  a_ctl_unimpl: assert property (s_rd_at(vic_pkg::OFS_CONTROL) |-> (reg_rdata & ~vic_pkg::CTL_MASK) == 32'h0)
    else $error("control spare bits set");
  a_stat_unimpl: assert property (s_rd_at(vic_pkg::OFS_STATUS) |-> (reg_rdata & ~vic_pkg::STAT_MASK) == 32'h0)
    else $error("status spare bits set");
  a_event_one_cycle: assert property (ext_event != 5'h00 |=> (ext_event & $past(ext_event)) == 5'h00)
    else $error("edge event longer than one cycle");
  a_reset_clear: assert property (disable iff (1'b0) $fell(rst) |-> !core_irq && core_level == 3'h0 && core_vector == 6'h00 && !core_multi && !core_shadow)
    else $error("outputs not clear after reset");
endmodule // vic_props
bind vic_top vic_props chk (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_event(ext_event), .core_irq(core_irq), .core_vector(core_vector),
  .core_level(core_level), .core_shadow(core_shadow), .core_multi(core_multi));
`default_nettype wire

/* verification/vic_core_model.sv */
// behavioural processor core taking vectors from the controller
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // controller side
  input wire logic core_irq,
  input wire logic core_multi,
  input wire logic [5:0] core_vector,
  // vector taken
  output logic [5:0] taken_vec
);
  // port vector used in multi mode only, status kept for single mode
  always_ff @(posedge sys_clk) begin
    if (rst) taken_vec <= 6'h00;
    else if (core_irq && core_multi) taken_vec <= core_vector;
  end
endmodule // vic_core_model
`default_nettype wire

/* verification/tb_vic_top.sv */
// self-checking testbench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_vic_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [24:0] src_req = 25'h0;
  logic [4:0] ext_pin = 5'h00;
  logic [4:0] ev_seen = 5'h00;
  logic ev_clr = 1'b0;
  logic [31:0] reg_rdata;
  logic core_irq, core_shadow, core_multi, proximity_running;
  logic [5:0] core_vector, taken_vec;
  logic [2:0] core_level;
  logic [4:0] ext_event;
  int num_errors = 0;
  int compares = 0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) ev_seen <= ev_clr ? 5'h00 : (ev_seen | ext_event);
  vic_top dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req),
    .ext_pin(ext_pin), .core_irq(core_irq), .core_vector(core_vector),
    .core_level(core_level), .core_shadow(core_shadow), .core_multi(core_multi),
    .ext_event(ext_event), .proximity_running(proximity_running));
  vic_core_model core (.sys_clk(sys_clk), .rst(rst), .core_irq(core_irq),
    .core_multi(core_multi), .core_vector(core_vector), .taken_vec(taken_vec));
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, string name);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(name, reg_rdata, exp);
  endtask
  task automatic pulse(logic [24:0] m);
    @(posedge sys_clk);
    src_req <= m;
    @(posedge sys_clk);
    src_req <= 25'h0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [5:0] vec_of(int n);
    if (n > 58) return 6'(n - 20);
    return (n < 42) ? 6'h20 : (n < 45) ? 6'h21 : (n < 48) ? 6'h22 : (n < 50) ? 6'h23 :
      (n < 53) ? 6'h24 : (n < 56) ? 6'h25 : 6'h26;
  endfunction
  task automatic tie(logic [24:0] m, logic [31:0] p, logic [5:0] v);
    wr(vic_pkg::OFS_PRIO_TEN, p);
    pulse(m);
    check("winner", taken_vec, v);
    wr(vic_pkg::OFS_FLAGS_UP, 32'h0);
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(vic_pkg::OFS_CONTROL, 32'h0, "ctl");
    rd(vic_pkg::OFS_STATUS, 32'h0, "stat");
    wr(vic_pkg::OFS_CONTROL, 32'hFFFF_FFFF);
    rd(vic_pkg::OFS_CONTROL, vic_pkg::CTL_MASK, "ctl");
    wr(vic_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    rd(vic_pkg::OFS_STATUS, vic_pkg::STAT_MASK, "stat");
    rd(8'hFC, 32'h0, "unmapped");
    wr(vic_pkg::OFS_CONTROL, 32'h15);
    ext_pin <= 5'h1F;
    repeat (8) @(posedge sys_clk);
    #1 check("rise", ev_seen, 32'h15);
    ev_clr <= 1'b1;
    @(posedge sys_clk);
    ev_clr <= 1'b0;
    ext_pin <= 5'h00;
    repeat (8) @(posedge sys_clk);
    #1 check("fall", ev_seen, 32'h0A);
    for (int i = 0; i < 25; i++) begin
      pulse(25'h1 << i);
      rd(vic_pkg::OFS_FLAGS_UP, 32'h1 << (i + 7), "flags");
      wr(vic_pkg::OFS_FLAGS_UP, 32'h0);
    end
    wr(vic_pkg::OFS_CONTROL, 32'h1000);
    wr(vic_pkg::OFS_PRIO_EIGHT, 32'h0C0C_0C0C);
    wr(vic_pkg::OFS_PRIO_NINE, 32'h0C0C_0C0C);
    wr(vic_pkg::OFS_PRIO_TEN, 32'h0C0C_0C0C);
    wr(vic_pkg::OFS_ENABLE_UP, 32'hFFFF_FF80);
    for (int n = 39; n < 64; n++) begin
      pulse(25'h1 << (n - 39));
      check("vector", core_vector, vec_of(n));
      check("level", core_level, 32'h3);
      wr(vic_pkg::OFS_FLAGS_UP, 32'h0);
    end
    rd(vic_pkg::OFS_STATUS, 32'h0000_032B, "stat");
    tie(25'h120_0000, 32'h0C0C_0C0C, 6'h28);
    tie(25'h120_0000, 32'h140C_0C0C, 6'h2B);
    tie(25'h060_0000, 32'h0C0C_0D0C, 6'h29);
    wr(vic_pkg::OFS_RELOAD, 32'h100);
    for (int k = 0; k < 4; k++) begin
      wr(vic_pkg::OFS_CONTROL, 32'h1000 | (32'(k) << 8));
      pulse(25'h20_0000);
      check("timer", proximity_running, 32'(k / 3));
      wr(vic_pkg::OFS_FLAGS_UP, 32'h0);
    end
    pulse(25'h20_0000);
    wr(vic_pkg::OFS_CONTROL, 32'h1_0000);
    repeat (2) @(posedge sys_clk);
    #1 check("single", {core_shadow, core_multi, core_vector}, 32'h80);
    wrap_up();
  end
endmodule // tb_vic_top
`default_nettype wire
